/* File: design/exen_map.svh */
// constants of the exception entry sequencer
`ifndef EXEN_MAP_SVH
`define EXEN_MAP_SVH
`define EXEN_ADDR_W       32
`define EXEN_STATUS_W     32
`define EXEN_SRC_W        4
`define EXEN_NMI_BIT      0
`define EXEN_INTDIS_BIT   18
`define EXEN_VEC_BASE     32'h00000000
`define EXEN_VEC_STRIDE   6
`define EXEN_PUSH_CYCLES  2'h1
`endif

/* File: design/exen_pkg.sv */
// types of the exception entry sequencer
package exen_pkg;
  typedef enum logic [1:0] {
    EXEN_RUN   = 2'h0,
    EXEN_DRAIN = 2'h1,
    EXEN_PUSH  = 2'h3,
    EXEN_VEC   = 2'h2
  } exen_state_type;
endpackage

/* File: design/exen_sequencer.sv */
// exception entry sequencer of the program sequencer
// How it works
// RULE1: break flow at earliest safe slot
// RULE2: one push cycle saves return pc and status_word
// RULE3: drive vector, enter exception mode, fetch on
// RULE4: handler flows as normal code, unbounded
// RULE5: push slot leads first handler set
// RULE6: delayed change-of-flow plus slot uninterruptible
// RULE7: no jump in sets one, two: push three
// RULE8: set two jump: push set two
// RULE9: set one jump: push set one
// RULE10: non-delayed flow change and disable act jumps
// RULE11: three-cycle jump example: push cycle ten
// RULE12: break point depends on neighbours and stalls
// RULE13: highest priority pending source wins
// RULE14: interrupt_disable masks all but non-maskable
// RULE15: source holds request until acknowledged
`timescale 1ns/1ps
`include "exen_map.svh"
module exen_sequencer
  import exen_pkg::*;
#(
  parameter int ADDR_W = `EXEN_ADDR_W,
  parameter int STATUS_W = `EXEN_STATUS_W,
  parameter int SRC_W  = `EXEN_SRC_W
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic [SRC_W-1:0]  excReq,
  input  wire logic              stall,
  input  wire logic              agenValid,
  input  wire logic [ADDR_W-1:0] agenPc,
  input  wire logic              agenJump,
  input  wire logic              agenDelayed,
  input  wire logic              agenSlot,
  input  wire logic [STATUS_W-1:0] statusWord,
  output logic                   excAck,
  output logic [SRC_W-1:0]       excAckId,
  output logic                   flushYounger,
  output logic                   pushValid,
  output logic [ADDR_W-1:0]      pushPc,
  output logic [STATUS_W-1:0]    pushStatusWord,
  output logic                   vecValid,
  output logic [ADDR_W-1:0]      vecAddr,
  output logic                   exceptionMode
);

  // ---------------------------------------------------------------
  // priority and masking
  // ---------------------------------------------------------------
  function automatic logic [SRC_W-1:0] pickSrc(input logic [SRC_W-1:0] req);
    logic [SRC_W-1:0] one;
    one = '0;
    for (int i = SRC_W - 1; i >= 0; i--) begin
      if (req[i]) begin
        one = '0;
        one[i] = 1'b1;
      end
    end
    return one;
  endfunction

  function automatic logic [ADDR_W-1:0] vecOf(input logic [SRC_W-1:0] oneHot);
    logic [ADDR_W-1:0] v;
    v = ADDR_W'(`EXEN_VEC_BASE);
    for (int i = 0; i < SRC_W; i++) begin
      if (oneHot[i]) begin
        v = ADDR_W'(`EXEN_VEC_BASE) + (ADDR_W'(i) << `EXEN_VEC_STRIDE);
      end
    end
    return v;
  endfunction

  exen_state_type   state_r;
  logic             inSeq_r;
  logic [SRC_W-1:0] live;
  logic [SRC_W-1:0] winner;
  logic             safe;

  // per source masking; the non-maskable source ignores the disable
  genvar g;
  generate
    for (g = 0; g < SRC_W; g++) begin : g_src
      if (g == `EXEN_NMI_BIT) begin : g_nmi
        assign live[g] = excReq[g];
      end else begin : g_mskd
        assign live[g] = excReq[g] & !statusWord[`EXEN_INTDIS_BIT]; // [RULE14]
      end
    end
  endgenerate

  assign winner = pickSrc(live); // [RULE13]

  // ---------------------------------------------------------------
  // safe slot tracking
  // ---------------------------------------------------------------
  // a delayed flow change opens a sequence closed by its delay slot
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      inSeq_r <= 1'b0;
    end else if (!stall && agenValid) begin
      if (agenDelayed) begin
        inSeq_r <= 1'b1; // [RULE6]
      end else if (agenSlot) begin
        inSeq_r <= 1'b0;
      end
    end
  end

  // break after the set now in address generation, unless it is a
  // jump or delayed sequence; at a jump the break waits for a later set
  assign safe = !stall && agenValid && !inSeq_r && !agenDelayed
                && !agenJump; // [RULE1] [RULE10] [RULE12]

  // ---------------------------------------------------------------
  // entry state machine
  // ---------------------------------------------------------------
  logic [SRC_W-1:0] held_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= EXEN_RUN;
      held_r  <= '0;
    end else begin
      case (state_r)
        EXEN_RUN: begin
          if (|winner && safe) begin
            held_r  <= winner;
            state_r <= EXEN_PUSH; // [RULE7] [RULE8] [RULE9] [RULE11]
          end else if (|winner) begin
            state_r <= EXEN_DRAIN; // [RULE15]
          end
        end
        EXEN_DRAIN: begin
          if (!(|winner)) begin
            state_r <= EXEN_RUN;
          end else if (safe) begin
            held_r  <= winner;
            state_r <= EXEN_PUSH;
          end
        end
        EXEN_PUSH: begin
          state_r <= EXEN_VEC; // [RULE2] [RULE5]
        end
        EXEN_VEC: begin
          state_r <= EXEN_RUN; // [RULE4]
        end
        default: begin
          state_r <= EXEN_RUN;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // take decision
  // ---------------------------------------------------------------
  // only the idle and waiting states may accept a new source;
  // push and vector states keep takes at least three cycles apart
  function automatic logic canTake(input exen_state_type s);
    logic ok;
    ok = 1'b0;
    if (s == EXEN_RUN) begin
      ok = 1'b1;
    end else if (s == EXEN_DRAIN) begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  logic takeNow;
  logic entryState;

  assign entryState = canTake(state_r);
  assign takeNow    = entryState && |winner && safe; // [RULE1]

  // ---------------------------------------------------------------
  // acknowledge outputs
  // ---------------------------------------------------------------
  // one cycle acknowledge pulse
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      excAck <= 1'b0;
    end else begin
      excAck <= takeNow; // [RULE1]
    end
  end

  // taken source, zero when idle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      excAckId <= '0;
    end else if (takeNow) begin
      excAckId <= winner; // [RULE13]
    end else begin
      excAckId <= '0;
    end
  end

  // younger sets are discarded at the break point
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flushYounger <= 1'b0;
    end else begin
      flushYounger <= takeNow; // [RULE5]
    end
  end

  // return address is the set after the break point
  logic [ADDR_W-1:0] retPc_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      retPc_r <= '0;
    end else if (takeNow) begin
      retPc_r <= agenPc + ADDR_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // push slot outputs
  // ---------------------------------------------------------------
  // push slot pulse, one cycle behind the acknowledge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pushValid <= 1'b0;
    end else begin
      pushValid <= (state_r == EXEN_PUSH); // [RULE2]
    end
  end

  // return address, held until the next push
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pushPc <= '0;
    end else if (state_r == EXEN_PUSH) begin
      pushPc <= retPc_r; // [RULE2]
    end
  end

  // status_word saved in the push cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pushStatusWord <= '0;
    end else if (state_r == EXEN_PUSH) begin
      pushStatusWord <= statusWord; // [RULE2]
    end
  end

  // ---------------------------------------------------------------
  // vector outputs
  // ---------------------------------------------------------------
  // vector strobe on the program address bus
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      vecValid <= 1'b0;
    end else begin
      vecValid <= takeNow; // [RULE3]
    end
  end

  // vector address, held for sequential fetch
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      vecAddr <= '0;
    end else if (takeNow) begin
      vecAddr <= vecOf(winner); // [RULE3]
    end
  end

  // ---------------------------------------------------------------
  // mode
  // ---------------------------------------------------------------
  // handler runs as normal flow; no exit is modelled here

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      exceptionMode <= 1'b0;
    end else if (takeNow) begin
      exceptionMode <= 1'b1; // [RULE3]
    end
  end

endmodule

/* File: test/exen_sequencer_monitor.sv */
// assertions of the exception entry sequencer
`timescale 1ns/1ps
module exen_sequencer_monitor (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [3:0]  excReq,
  input wire logic        stall,
  input wire logic        agenValid,
  input wire logic [31:0] agenPc,
  input wire logic        agenJump,
  input wire logic        agenDelayed,
  input wire logic [31:0] statusWord,
  input wire logic        excAck,
  input wire logic [3:0]  excAckId,
  input wire logic        flushYounger,
  input wire logic        pushValid,
  input wire logic [31:0] pushPc,
  input wire logic        vecValid,
  input wire logic [31:0] vecAddr,
  input wire logic        exceptionMode
);
  logic [3:0] elig;
  logic [3:0] win;
  assign elig = excReq & (statusWord[18] ? 4'h1 : 4'hF);
  assign win  = elig & (~elig + 4'h1);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_take; excAck; endsequence
  sequence s_push; pushValid && !excAck; endsequence
  property p_flush; s_take |-> flushYounger && vecValid && exceptionMode; endproperty
  a_flush: assert property (p_flush) else $error("ack without vector");
  property p_entry; s_take |=> s_push; endproperty
  a_entry: assert property (p_entry) else $error("no push after ack");
  property p_safe; excAck |-> !$past(stall) && $past(agenValid); endproperty
  a_safe: assert property (p_safe) else $error("taken in stall");
  property p_cof; excAck |-> !$past(agenJump) && !$past(agenDelayed); endproperty
  a_cof: assert property (p_cof) else $error("taken at flow change");
  property p_win; excAck |-> excAckId == $past(win) && excAckId != 4'h0; endproperty
  a_win: assert property (p_win) else $error("wrong source");
  property p_vec; excAck |-> vecAddr == {24'h0, excAckId[3] | excAckId[2], excAckId[3] | excAckId[1], 6'h00};
  endproperty
  a_vec: assert property (p_vec) else $error("wrong vector");
  property p_pc; pushValid |-> pushPc == $past(agenPc, 2) + 32'h1; endproperty
  a_pc: assert property (p_pc) else $error("wrong return pc");
  property p_hold; exceptionMode |=> exceptionMode; endproperty
  a_hold: assert property (p_hold) else $error("mode dropped");
endmodule
bind exen_sequencer exen_sequencer_monitor mon_u (.clk_sys, .rst_n, .excReq, .stall, .agenValid, .agenPc,
  .agenJump, .agenDelayed, .statusWord, .excAck, .excAckId, .flushYounger, .pushValid, .pushPc, .vecValid,
  .vecAddr, .exceptionMode);

/* File: test/exen_src_model.sv */
// request source holding each request until taken
`timescale 1ns/1ps
module exen_src_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic [3:0] raise,
  input  wire logic       excAck,
  input  wire logic [3:0] excAckId,
  output logic      [3:0] excReq
);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) excReq <= 4'h0;
    else excReq <= (excReq | raise) & ~(excAck ? excAckId : 4'h0);
  end
endmodule

/* File: test/exen_sequencer_tb.sv */
// self-checking bench of the exception entry sequencer
`timescale 1ns/1ps
module exen_sequencer_tb;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  raise = 4'h0;
  logic [3:0]  blk = 4'h0;
  logic        slot = 1'b0;
  logic        intDisable = 1'b0;
  logic [31:0] agenPc = 32'h100;
  logic [3:0]  excReq, excAckId;
  logic        excAck, flushYounger, pushValid, vecValid, exceptionMode;
  logic [31:0] pushPc, pushStatusWord, vecAddr, statusWord;
  int          mismatches = 0;
  int          nTests = 0;
  assign statusWord = {13'h0, intDisable, 18'h000A5};
  always #25 clk_sys = ~clk_sys;
  always_ff @(posedge clk_sys) agenPc <= agenPc + 32'h1;
  exen_src_model src_u (.clk_sys, .rst_n, .raise, .excAck, .excAckId, .excReq);
  exen_sequencer dut_u (.clk_sys, .rst_n, .excReq, .stall(blk[0]), .agenValid(!blk[3]), .agenPc,
    .agenJump(blk[1]), .agenDelayed(blk[2]), .agenSlot(slot), .statusWord, .excAck, .excAckId,
    .flushYounger, .pushValid, .pushPc, .pushStatusWord, .vecValid, .vecAddr, .exceptionMode);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic pulse(input logic [3:0] v);
    raise <= v;
    @(posedge clk_sys);
    raise <= 4'h0;
  endtask
  task automatic quiet();
    repeat (6) begin
      @(posedge clk_sys) #1;
      chk(32'(excAck), 32'h0);
    end
    @(posedge clk_sys);
  endtask
  task automatic w_ack(input logic [31:0] id, input logic [31:0] vec);
    logic [31:0] ret;
    #1;
    for (int n = 0; n < 20 && excAck !== 1'b1; n++) @(posedge clk_sys) #1;
    chk(32'(excAck), 32'h1);
    chk(32'(flushYounger), 32'h1);
    chk(32'(vecValid), 32'h1);
    chk(32'(exceptionMode), 32'h1);
    chk(32'(excAckId), id);
    chk(vecAddr, vec);
    ret = agenPc;
    @(posedge clk_sys) #1;
    chk(32'(pushValid), 32'h1);
    chk(pushPc, ret);
    chk(pushStatusWord, statusWord);
  endtask
  task automatic t_prio();
    pulse(4'hA);
    w_ack(32'h2, 32'h40);
    w_ack(32'h8, 32'hC0);
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic t_defer();
    for (int k = 0; k < 4; k++) begin
      blk <= 4'h1 << k;
      pulse(4'h4);
      quiet();
      slot <= blk[2];
      blk <= 4'h0;
      @(posedge clk_sys);
      slot <= 1'b0;
      w_ack(32'h4, 32'h80);
      repeat (4) @(posedge clk_sys);
    end
  endtask
  task automatic t_mask();
    intDisable <= 1'b1;
    pulse(4'h2);
    quiet();
    pulse(4'h1);
    w_ack(32'h1, 32'h0);
    @(posedge clk_sys);
    intDisable <= 1'b0;
    w_ack(32'h2, 32'h40);
  endtask
  task automatic complete_run();
    if (mismatches == 0 && nTests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_prio();
    t_defer();
    t_mask();
    complete_run();
  end
  initial begin
    #100000;
    mismatches++;
    complete_run();
  end
endmodule
